// ===== common/uart_baud_cfg.svh
/*
  register offsets, field positions, reset values and timing figures of the
  serial port baud and status logic. assumes a 100 MHz register clock.
*/
`ifndef UART_BAUD_CFG_SVH
`define UART_BAUD_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_DEGLITCH 8'h00
`define OFF_PRESCALE 8'h04
`define OFF_MODULATION 8'h08
`define OFF_STATUS 8'h0C
`define OFF_CONTROL 8'h10
`define OFF_RXBUF 8'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MOD_OS_BIT 0
`define MOD_FIRST_LSB 4
`define MOD_SECOND_LSB 8
`define ST_BUSY 0
`define ST_ADDR_IDLE 1
`define ST_RXERR 2
`define ST_BREAK 3
`define ST_PARITY 4
`define ST_OVERRUN 5
`define ST_FRAMING 6
`define ST_LOOPBACK 7
`define CTL_HOLD_BIT 0
`define CTL_PAR_BIT 1
`define CTL_MODE_LSB 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DEGLITCH 2'h3
`define RST_PRESCALE 16'h0000
`define RST_MODULATION 16'h0000
`define RST_CONTROL 4'h1

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define GLITCH0_NS 2
`define GLITCH1_NS 50
`define GLITCH2_NS 100
`define GLITCH3_NS 200
`define NS_TO_CYC(ns) (((ns) < `CLK_PERIOD_NS) ? 1 : ((ns) / `CLK_PERIOD_NS))
`define OS_LAST_TICK 4'hF

`endif

// ===== common/uart_baud_pkg.sv
/*
  types shared by the serial port baud and status logic.
  assumes uart_baud_cfg.svh for all figures.
*/
package uart_baud_pkg;
	typedef enum logic [1:0] {
		MODE_PLAIN,
		MODE_IDLE_LINE,
		MODE_ADDR_BIT,
		MODE_AUTO_BAUD
	} async_mode_t;
	typedef logic [15:0] word_t;
endpackage : uart_baud_pkg

// ===== verilog/line_deglitch.sv
/*
  receive line glitch filter: a level passes only after it has held for the
  selected number of clocks. assumes line_i is already synchronised.
*/
`timescale 1ns/10ps
`include "uart_baud_cfg.svh"

module line_deglitch (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic line_i,
	input wire logic [1:0] sel_i,
	output logic line_o
);
	logic [4:0] count;
	logic [4:0] next_count;
	logic next_line;
	logic [4:0] need;

	// ----------------------------------------------------------------
	// filter
	// ----------------------------------------------------------------
	always_comb begin
		unique case (sel_i)
			2'h0: need = 5'(`NS_TO_CYC(`GLITCH0_NS));
			2'h1: need = 5'(`NS_TO_CYC(`GLITCH1_NS));
			2'h2: need = 5'(`NS_TO_CYC(`GLITCH2_NS));
			2'h3: need = 5'(`NS_TO_CYC(`GLITCH3_NS));
		endcase
		next_line = line_o;
		next_count = 5'h00;
		if (line_i != line_o) begin
			// a pulse shorter than the window restarts the count and is lost
			if (count + 5'h01 >= need) begin
				next_line = line_i;
			end else begin
				next_count = count + 5'h01;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			count <= 5'h00;
			line_o <= 1'h1;
		end else begin
			count <= next_count;
			line_o <= next_line;
		end
	end
endmodule : line_deglitch

// ===== verilog/uart_baud_status.sv
/*
  baud generator, glitch filter selection and status flags of an
  asynchronous serial port, with an APB register slave.
  assumes the receiver and transmitter run on clk_i and report events as
  single-cycle pulses; rx_pin_i comes straight from the pin.
*/
// Chosen here: the APB slave port and the register addresses.
// How it works
// - deglitch code 0..3 picks about 2, 50, 100 or 200 ns; resets to 3.
// - 16-bit prescaler, reset zero, divides the clock for the baud generator.
// - 8-bit second pattern adds one clock to chosen bit periods.
// - 4-bit first pattern stretches oversample ticks, only when oversampling.
// - modulation bit 0 turns oversampling on; resets off.
// - loopback feeds the transmit line into the receiver.
// - framing flag sets on low stop bit, clears on buffer read.
// - overrun flag sets when an unread buffer is overwritten, clears on read.
// - parity flag sets on bad parity, reads 0 with parity off, clears on read.
// - break flag sets on received break, clears on buffer read.
// - summary error flag sets with framing, parity or overrun; clears on read.
// - bit 1 marks address character or idle line per mode; clears on read.
// - busy bit reads 1 while sending or receiving, but 0 while the hold bit is set.
// - mode 00 plain, 01 idle-line, 10 address-bit, 11 auto-baud.
// - buffer read clears error flags, address/idle flag and receive flag.
`timescale 1ns/10ps
`include "uart_baud_cfg.svh"

module uart_baud_status (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rx_pin_i,
	input wire logic transmit_line_i,
	output logic rx_line_o,
	output logic bit_clock_o,
	output logic oversample_clock_o,
	output logic soft_reset_hold_o,
	output logic parity_enable_o,
	output logic [1:0] async_mode_select_o,
	output logic receive_flag_o,
	input wire logic rx_load_i,
	input wire logic [7:0] rx_char_i,
	input wire logic rx_stop_low_i,
	input wire logic rx_parity_bad_i,
	input wire logic rx_break_i,
	input wire logic rx_addr_bit_i,
	input wire logic rx_idle_seen_i,
	input wire logic tx_active_i,
	input wire logic rx_active_i
);
	logic [1:0] deglitch_select, next_deglitch_select;
	logic [15:0] baud_prescaler, next_baud_prescaler;
	logic [7:0] second_mod_pattern, next_second_mod_pattern;
	logic [3:0] first_mod_pattern, next_first_mod_pattern;
	logic oversample_enable, next_oversample_enable;
	logic soft_reset_hold, next_soft_reset_hold;
	logic parity_enable, next_parity_enable;
	uart_baud_pkg::async_mode_t async_mode_select, next_async_mode_select;
	logic loopback_enable, next_loopback_enable;
	logic framing_error_flag, next_framing_error_flag;
	logic overrun_flag, next_overrun_flag;
	logic parity_error_flag, next_parity_error_flag;
	logic break_flag, next_break_flag;
	logic receive_error_flag, next_receive_error_flag;
	logic addr_idle_flag, next_addr_idle_flag;
	logic rx_full, next_rx_full;
	logic [7:0] receive_buffer, next_receive_buffer;
	logic [31:0] next_prdata;
	logic addr_err, next_addr_err;
	logic setup, access, wr, rxbuf_read, load;
	logic activity_flag;
	uart_baud_pkg::word_t status_word;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i;
	assign wr = access & pwrite_i & ~addr_err;
	assign rxbuf_read = access & ~pwrite_i & (paddr_i == `OFF_RXBUF);
	assign pready_o = access;
	assign pslverr_o = access & addr_err;
	assign load = rx_load_i & ~soft_reset_hold;
	assign activity_flag = (tx_active_i | rx_active_i) & ~soft_reset_hold;

	always_comb begin
		status_word = 16'h0000;
		status_word[`ST_LOOPBACK] = loopback_enable;
		status_word[`ST_FRAMING] = framing_error_flag;
		status_word[`ST_OVERRUN] = overrun_flag;
		status_word[`ST_PARITY] = parity_error_flag & parity_enable;
		status_word[`ST_BREAK] = break_flag;
		status_word[`ST_RXERR] = receive_error_flag;
		status_word[`ST_ADDR_IDLE] = addr_idle_flag;
		status_word[`ST_BUSY] = activity_flag;
	end

	// read data is caught in the setup cycle so it leaves a flip-flop
	always_comb begin
		next_prdata = prdata_o;
		next_addr_err = addr_err;
		if (setup) begin
			next_addr_err = 1'h0;
			next_prdata = 32'h0000_0000;
			unique case (paddr_i)
				`OFF_DEGLITCH: next_prdata[1:0] = deglitch_select;
				`OFF_PRESCALE: next_prdata[15:0] = baud_prescaler;
				`OFF_MODULATION: next_prdata[15:0] = {second_mod_pattern, first_mod_pattern, 3'h0, oversample_enable};
				`OFF_STATUS: next_prdata[15:0] = status_word;
				`OFF_CONTROL: next_prdata[3:0] = {async_mode_select, parity_enable, soft_reset_hold};
				`OFF_RXBUF: next_prdata[7:0] = receive_buffer;
				default: next_addr_err = 1'h1;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prdata_o <= 32'h0000_0000;
			addr_err <= 1'h0;
		end else begin
			prdata_o <= next_prdata;
			addr_err <= next_addr_err;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// writes are taken at any time; keeping them under the hold bit is up to software
	always_comb begin
		next_deglitch_select = deglitch_select;
		next_baud_prescaler = baud_prescaler;
		next_second_mod_pattern = second_mod_pattern;
		next_first_mod_pattern = first_mod_pattern;
		next_oversample_enable = oversample_enable;
		next_soft_reset_hold = soft_reset_hold;
		next_parity_enable = parity_enable;
		next_async_mode_select = async_mode_select;
		next_loopback_enable = loopback_enable;
		if (wr) begin
			unique case (paddr_i)
				`OFF_DEGLITCH: next_deglitch_select = pwdata_i[1:0];
				`OFF_PRESCALE: next_baud_prescaler = pwdata_i[15:0];
				`OFF_MODULATION: begin
					next_second_mod_pattern = pwdata_i[`MOD_SECOND_LSB +: 8];
					next_first_mod_pattern = pwdata_i[`MOD_FIRST_LSB +: 4];
					next_oversample_enable = pwdata_i[`MOD_OS_BIT];
				end
				`OFF_STATUS: next_loopback_enable = pwdata_i[`ST_LOOPBACK];
				`OFF_CONTROL: begin
					next_soft_reset_hold = pwdata_i[`CTL_HOLD_BIT];
					next_parity_enable = pwdata_i[`CTL_PAR_BIT];
					next_async_mode_select = uart_baud_pkg::async_mode_t'(pwdata_i[`CTL_MODE_LSB +: 2]);
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			deglitch_select <= `RST_DEGLITCH;
			baud_prescaler <= `RST_PRESCALE;
			{second_mod_pattern, first_mod_pattern} <= 12'h000;
			oversample_enable <= 1'h0;
			async_mode_select <= uart_baud_pkg::async_mode_t'(2'(`RST_CONTROL >> `CTL_MODE_LSB));
			{parity_enable, soft_reset_hold} <= 2'(`RST_CONTROL);
			loopback_enable <= 1'h0;
		end else begin
			deglitch_select <= next_deglitch_select;
			baud_prescaler <= next_baud_prescaler;
			second_mod_pattern <= next_second_mod_pattern;
			first_mod_pattern <= next_first_mod_pattern;
			oversample_enable <= next_oversample_enable;
			soft_reset_hold <= next_soft_reset_hold;
			parity_enable <= next_parity_enable;
			async_mode_select <= next_async_mode_select;
			loopback_enable <= next_loopback_enable;
		end
	end

	assign soft_reset_hold_o = soft_reset_hold;
	assign parity_enable_o = parity_enable;
	assign async_mode_select_o = async_mode_select;
	assign receive_flag_o = rx_full;

	// ----------------------------------------------------------------
	// status flags
	// ----------------------------------------------------------------
	// a load in the same cycle as a buffer read wins over the clear
	always_comb begin
		next_framing_error_flag = framing_error_flag;
		next_overrun_flag = overrun_flag;
		next_parity_error_flag = parity_error_flag;
		next_break_flag = break_flag;
		next_receive_error_flag = receive_error_flag;
		next_addr_idle_flag = addr_idle_flag;
		next_rx_full = rx_full;
		next_receive_buffer = receive_buffer;
		if (wr && paddr_i == `OFF_STATUS) begin
			next_framing_error_flag = pwdata_i[`ST_FRAMING];
			next_overrun_flag = pwdata_i[`ST_OVERRUN];
			next_parity_error_flag = pwdata_i[`ST_PARITY];
			next_break_flag = pwdata_i[`ST_BREAK];
			next_receive_error_flag = pwdata_i[`ST_RXERR];
			next_addr_idle_flag = pwdata_i[`ST_ADDR_IDLE];
		end
		if (rxbuf_read) begin
			next_framing_error_flag = 1'h0;
			next_overrun_flag = 1'h0;
			next_parity_error_flag = 1'h0;
			next_break_flag = 1'h0;
			next_receive_error_flag = 1'h0;
			next_addr_idle_flag = 1'h0;
			next_rx_full = 1'h0;
		end
		if (load) begin
			next_receive_buffer = rx_char_i;
			next_rx_full = 1'h1;
			next_framing_error_flag = next_framing_error_flag | rx_stop_low_i;
			next_overrun_flag = next_overrun_flag | (rx_full & ~rxbuf_read);
			next_parity_error_flag = next_parity_error_flag | (rx_parity_bad_i & parity_enable);
			next_break_flag = next_break_flag | rx_break_i;
			next_receive_error_flag = next_receive_error_flag | rx_stop_low_i | (rx_full & ~rxbuf_read)
				| (rx_parity_bad_i & parity_enable);
			unique case (async_mode_select)
				uart_baud_pkg::MODE_IDLE_LINE: next_addr_idle_flag = rx_idle_seen_i;
				uart_baud_pkg::MODE_ADDR_BIT: next_addr_idle_flag = rx_addr_bit_i;
				uart_baud_pkg::MODE_PLAIN, uart_baud_pkg::MODE_AUTO_BAUD: next_addr_idle_flag = 1'h0;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			{framing_error_flag, overrun_flag, parity_error_flag} <= 3'h0;
			{break_flag, receive_error_flag, addr_idle_flag, rx_full} <= 4'h0;
			receive_buffer <= 8'h00;
		end else begin
			framing_error_flag <= next_framing_error_flag;
			overrun_flag <= next_overrun_flag;
			parity_error_flag <= next_parity_error_flag;
			break_flag <= next_break_flag;
			receive_error_flag <= next_receive_error_flag;
			addr_idle_flag <= next_addr_idle_flag;
			rx_full <= next_rx_full;
			receive_buffer <= next_receive_buffer;
		end
	end

	// ----------------------------------------------------------------
	// receive line: synchroniser, filter, loopback
	// ----------------------------------------------------------------
	logic pin_meta, pin_sync, pin_clean, next_rx_line;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pin_meta <= 1'h1;
			pin_sync <= 1'h1;
		end else begin
			pin_meta <= rx_pin_i;
			pin_sync <= pin_meta;
		end
	end

	line_deglitch filter (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.line_i(pin_sync),
		.sel_i(deglitch_select),
		.line_o(pin_clean)
	);

	assign next_rx_line = loopback_enable ? transmit_line_i : pin_clean;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			rx_line_o <= 1'h1;
		end else begin
			rx_line_o <= next_rx_line;
		end
	end

	// ----------------------------------------------------------------
	// baud generator
	// ----------------------------------------------------------------
	logic [16:0] div_count, next_div_count, period;
	logic [3:0] tick_index, next_tick_index;
	logic [2:0] bit_index, next_bit_index;
	logic next_bit_clock, next_oversample_clock;

	// a zero prescaler would never divide, so it counts as one
	always_comb begin
		period = (baud_prescaler == 16'h0000) ? 17'h00001 : {1'h0, baud_prescaler};
		if (oversample_enable) begin
			if (first_mod_pattern > tick_index) begin
				period = period + 17'h00001;
			end
			if (tick_index == `OS_LAST_TICK) begin
				period = period + {16'h0000, second_mod_pattern[bit_index]};
			end
		end else begin
			period = period + {16'h0000, second_mod_pattern[bit_index]};
		end
		next_div_count = div_count + 17'h00001;
		next_tick_index = tick_index;
		next_bit_index = bit_index;
		next_bit_clock = 1'h0;
		next_oversample_clock = 1'h0;
		if (next_div_count >= period) begin
			next_div_count = 17'h00000;
			if (oversample_enable) begin
				next_oversample_clock = 1'h1;
				next_tick_index = tick_index + 4'h1;
				next_bit_clock = (tick_index == `OS_LAST_TICK);
			end else begin
				next_tick_index = 4'h0;
				next_bit_clock = 1'h1;
			end
			next_bit_index = bit_index + 3'(next_bit_clock);
		end
		if (soft_reset_hold) begin
			next_div_count = 17'h00000;
			next_tick_index = 4'h0;
			next_bit_index = 3'h0;
			next_bit_clock = 1'h0;
			next_oversample_clock = 1'h0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_count <= 17'h00000;
			tick_index <= 4'h0;
			bit_index <= 3'h0;
			bit_clock_o <= 1'h0;
			oversample_clock_o <= 1'h0;
		end else begin
			div_count <= next_div_count;
			tick_index <= next_tick_index;
			bit_index <= next_bit_index;
			bit_clock_o <= next_bit_clock;
			oversample_clock_o <= next_oversample_clock;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking chk @(posedge clk_i); endclocking
	default disable iff (reset_i);

	deglitch_reset_a: assert property ($fell(reset_i) |-> deglitch_select == `RST_DEGLITCH)
		else $error("deglitch select not at reset code");
	prescale_period_a: assert property (disable iff (reset_i || soft_reset_hold) bit_clock_o
		&& !oversample_enable && second_mod_pattern == 8'h00 && baud_prescaler == 16'h0004
		|=> !bit_clock_o [*3] ##1 bit_clock_o)
		else $error("bit clock period differs from prescaler");
	second_stage_a: assert property (disable iff (reset_i || soft_reset_hold) bit_clock_o
		&& !oversample_enable && second_mod_pattern == 8'hFF && baud_prescaler == 16'h0004
		|=> !bit_clock_o [*4] ##1 bit_clock_o)
		else $error("second stage did not stretch bit period");
	os_tick_align_a: assert property (bit_clock_o && $past(oversample_enable) |-> oversample_clock_o)
		else $error("bit clock off the oversample grid");
	os_off_a: assert property (!oversample_enable && !$past(oversample_enable) |-> !oversample_clock_o)
		else $error("oversample tick while disabled");
	loopback_path_a: assert property (loopback_enable |=> rx_line_o == $past(transmit_line_i))
		else $error("loopback not routed");
	framing_set_a: assert property (load && rx_stop_low_i |=> framing_error_flag && receive_error_flag)
		else $error("framing flag not set");
	overrun_set_a: assert property (load && rx_full && !rxbuf_read |=> overrun_flag && receive_error_flag)
		else $error("overrun flag not set");
	parity_mask_a: assert property (setup && paddr_i == `OFF_STATUS && !parity_enable |=> !prdata_o[`ST_PARITY])
		else $error("parity flag visible with parity off");
	read_clear_a: assert property (rxbuf_read && !load |=> status_word[6:1] == 6'h00 && !rx_full)
		else $error("buffer read left flags set");
	busy_hold_a: assert property (soft_reset_hold |-> !status_word[`ST_BUSY])
		else $error("busy shown under soft reset");
	load_same_a: assert property (load |=> receive_buffer == $past(rx_char_i) && rx_full)
		else $error("buffer not loaded with flags");

	overrun_seen_c: cover property (load && rx_full);
	os_bit_c: cover property (bit_clock_o && oversample_enable);
	loop_read_c: cover property (loopback_enable && rxbuf_read);
	idle_mode_c: cover property (load && async_mode_select == uart_baud_pkg::MODE_IDLE_LINE && rx_idle_seen_i);
endmodule : uart_baud_status

// ===== tb/remote_station.sv
/*
  remote serial station: drives the raw receive pin of the port.
  assumes the pin has a pull-up, so the line idles high between frames.
*/
`timescale 1ns/10ps

module remote_station (
	output logic line_o
);
	initial line_o = 1'b1;

	// ----
	// line events
	// ----
	// low pulse of a chosen length: a start bit, or a glitch when short
	task automatic pulse_low(input int ns);
		line_o <= 1'b0;
		#(ns);
		line_o <= 1'b1;
	endtask : pulse_low
endmodule : remote_station

// ===== tb/uart_baud_and_status_regs_test.sv
/*
  self-checking bench of the baud and status block against a small model.
  assumes the APB slave of uart_baud_status and the remote_station model.
*/
`timescale 1ns/10ps
`include "uart_baud_cfg.svh"

module uart_baud_and_status_regs_test;
	logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, perr;
	logic [7:0] paddr, ch;
	logic [31:0] pwdata, prdata, rd;
	logic rx_pin, tx_line, rx_line, bclk, osclk, hold, par, rf;
	logic [1:0] mode, em;
	logic ld, stp, pbad, brk, ab, idl, txa, rxa, ep, eh;
	int err_count, num_checks, exp_st, exp_buf, exp_rf, n, lows;
	int pv[5] = '{4, 4, 4, 2, 2};
	int mv[5] = '{'h0000, 'h00F0, 'hFF00, 'h0001, 'h00F1};
	int gv[5] = '{4, 4, 5, 2, 47};

	remote_station PEER (.line_o(rx_pin));
	uart_baud_status DUT (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .rx_pin_i(rx_pin), .transmit_line_i(tx_line), .rx_line_o(rx_line),
		.bit_clock_o(bclk), .oversample_clock_o(osclk), .soft_reset_hold_o(hold),
		.parity_enable_o(par), .async_mode_select_o(mode), .receive_flag_o(rf), .rx_load_i(ld),
		.rx_char_i(ch), .rx_stop_low_i(stp), .rx_parity_bad_i(pbad), .rx_break_i(brk),
		.rx_addr_bit_i(ab), .rx_idle_seen_i(idl), .tx_active_i(txa), .rx_active_i(rxa));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	// ----
	// shared tasks
	// ----
	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test

	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	// request held until pready is seen high; data and error taken at that edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk_i);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		perr = pslverr;
		{psel, penable} <= 2'b00;
		if (k >= 50) begin
			err_count++;
			stop_test();
		end
		// registered outputs updated at the access edge are read once settled
		#1;
	endtask : apb

	task automatic ctl(input logic h);
		eh = h;
		apb(1'b1, `OFF_CONTROL, {28'h0, em, ep, h});
	endtask : ctl

	task automatic chk_st;
		apb(1'b0, `OFF_STATUS, 32'h0);
		check("status", rd, exp_st);
	endtask : chk_st

	task automatic rdbuf;
		apb(1'b0, `OFF_RXBUF, 32'h0);
		check("rxbuf", rd, exp_buf);
		exp_st &= 'h80;
		exp_rf = 0;
		check("rxflag", rf, 32'(exp_rf));
	endtask : rdbuf

	// one receiver event; loads under hold are refused, so the model skips them
	task automatic load(input logic s, p, b, a, i);
		logic [7:0] c;
		c = 8'($urandom);
		@(posedge clk_i);
		{ld, ch, stp, pbad, brk, ab, idl} <= {1'b1, c, s, p, b, a, i};
		@(posedge clk_i);
		ld <= 1'b0;
		if (!eh) begin
			if (exp_rf != 0) exp_st |= 'h24;
			if (s) exp_st |= 'h44;
			if (p && ep) exp_st |= 'h14;
			if (b) exp_st |= 'h08;
			if ((em == 2'd2 && a) || (em == 2'd1 && i)) exp_st |= 'h02;
			exp_buf = c;
			exp_rf = 1;
		end
		#1;
	endtask : load

	task automatic gap(input logic os);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge clk_i);
				#1;
				n++;
			end while ((os ? osclk : bclk) !== 1'b1 && n < 200);
			if (n >= 200) begin
				err_count++;
				stop_test();
			end
		end
	endtask : gap

	task automatic watch(input int ns);
		lows = 0;
		fork
			PEER.pulse_low(ns);
			repeat (40) @(negedge clk_i) lows += (rx_line === 1'b0);
		join
	endtask : watch

	// ----
	// main sequence
	// ----
	initial begin
		{reset_i, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{tx_line, ld, ch, stp, pbad, brk, ab, idl, txa, rxa} = {1'b1, 16'h0};
		{err_count, num_checks, exp_st, exp_rf} = '0;
		{em, ep, eh} = 4'h1;
		void'($urandom(32'h064B));
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		apb(1'b0, `OFF_DEGLITCH, 32'h0);
		check("deglitch", rd, 32'h3);
		apb(1'b0, `OFF_PRESCALE, 32'h0);
		check("prescale", rd, 32'h0);
		apb(1'b0, `OFF_MODULATION, 32'h0);
		check("modulation", rd, 32'h0);
		chk_st();
		check("hold", hold, 32'h1);
		for (int k = 0; k < 3; k++) begin
			n = $urandom;
			apb(1'b1, 8'h00 + 8'(4 * k), n);
			apb(1'b0, 8'h00 + 8'(4 * k), 32'h0);
			check("readback", rd, n & (k == 0 ? 'h3 : k == 1 ? 'hFFFF : 'hFFF1));
		end
		apb(1'b1, 8'h18, 32'hFFFF);
		check("unmapped error", perr, 32'h1);
		$display("test registers done");
		for (int k = 0; k < 5; k++) begin
			ctl(1'b1);
			apb(1'b1, `OFF_PRESCALE, pv[k]);
			apb(1'b1, `OFF_MODULATION, mv[k]);
			ctl(1'b0);
			gap(k == 3);
			check("baud gap", n, gv[k]);
		end
		$display("test baud done");
		load(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		check("rxflag", rf, 32'h1);
		chk_st();
		load(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		chk_st();
		rdbuf();
		chk_st();
		ep = 1'b1;
		ctl(1'b0);
		check("parity out", par, 32'h1);
		load(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
		chk_st();
		ep = 1'b0;
		ctl(1'b0);
		exp_st &= 'hEF;
		chk_st();
		rdbuf();
		load(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
		chk_st();
		rdbuf();
		for (int m = 0; m < 4; m++) begin
			em = 2'(m);
			ctl(1'b0);
			check("mode", mode, 32'(m));
			load(1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
			chk_st();
			rdbuf();
		end
		ctl(1'b1);
		load(1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
		chk_st();
		check("rxflag", rf, 32'h0);
		$display("test status done");
		ctl(1'b0);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_i);
			{txa, rxa} <= 2'(2 >> k);
			apb(1'b0, `OFF_STATUS, 32'h0);
			check("busy", rd, (k < 2) ? 32'h1 : 32'h0);
		end
		apb(1'b1, `OFF_DEGLITCH, 32'h3);
		watch(100);
		check("glitch lows", lows, 32'h0);
		apb(1'b1, `OFF_DEGLITCH, 32'h1);
		watch(100);
		check("pulse passed", lows > 0, 32'h1);
		ctl(1'b1);
		apb(1'b1, `OFF_STATUS, 32'h80);
		exp_st = 'h80;
		ctl(1'b0);
		chk_st();
		@(posedge clk_i);
		tx_line <= 1'b0;
		@(posedge clk_i);
		#1;
		check("loopback", rx_line, 32'h0);
		tx_line <= 1'b1;
		$display("test line done");
		stop_test();
	end
endmodule : uart_baud_and_status_regs_test
